// >>> hdl/battery_status_defines.vh
// Constants for the battery status flag and read-only function block
`ifndef BATTERY_STATUS_DEFINES_VH
`define BATTERY_STATUS_DEFINES_VH

// Function codes
`define FC_STATUS_WORD        8'h16
`define FC_CYCLE_COUNT        8'h17
`define FC_DESIGN_CAPACITY    8'h18
`define FC_DESIGN_VOLTAGE     8'h19
`define FC_SPEC_INFO          8'h1A
`define FC_DEFINED_LAST       8'h23
`define FC_RSVD_LO_FIRST      8'h1D
`define FC_RSVD_LO_LAST       8'h1F
`define FC_MFR_FIRST          8'h2F

// Status word bit positions
`define ST_OVER_CHARGED       15
`define ST_STOP_CHARGE        14
`define ST_OVER_TEMP          12
`define ST_STOP_DISCHARGE     11
`define ST_CAPACITY_ALARM     9
`define ST_TIME_ALARM         8
`define ST_CONFIG_LOADED      7
`define ST_DISCHARGING        6
`define ST_FULLY_CHARGED      5
`define ST_FULLY_DISCHARGED   4
`define ST_ERR_MSB            2
`define ST_ERR_LSB            0

// Error codes
`define ERR_OK                3'h0
`define ERR_BUSY              3'h1
`define ERR_RESERVED          3'h2
`define ERR_UNSUPPORTED       3'h3
`define ERR_WRITE_DENIED      3'h4
`define ERR_OVERFLOW          3'h5
`define ERR_WRONG_SIZE        3'h6
`define ERR_UNKNOWN           3'h7

// Specification word fields
`define SPEC_VER_LOW_LSB      0
`define SPEC_VER_HIGH_LSB     4
`define SPEC_VOLTAGE_SCALE_FIELD_LSB       8
`define SPEC_ISCALE_LSB       12

// Reset values
`define RST_WORD              16'h0000
`define RST_ERR               3'h0
`define CYCLE_MAX             16'hFFFF

// Timing
`define CLK_PERIOD_NS         5
`define FILTER_TICK_S         1
`define FILTER_SECONDS_PER    10
`define FULL_DISCH_CLEAR_PCT  7'h14
`define PERCENT_SCALE         7'h64

`endif

// >>> hdl/battery_status_flag_logic.v
// Status word flags, error code and read-only information functions
`include "battery_status_defines.vh"

module battery_status_flag_logic #(
  parameter SEC_CYCLES = (`FILTER_TICK_S * 1000000000) / `CLK_PERIOD_NS,
  parameter CNT_W      = 28
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst_n,
  // Function access, one request per pulse
  input  wire        func_req,
  input  wire        func_write,
  input  wire [7:0]  func_code,
  input  wire        func_busy,
  input  wire        func_overflow,
  output reg         func_ack,
  output reg  [15:0] func_rdata,
  // Gauge measurements, sampled on gauge_update; activity, filter and overcharge inputs also feed the idle clear
  input  wire        gauge_update,
  input  wire [15:0] pack_voltage,
  input  wire [15:0] end_discharge_level_zero,
  input  wire [15:0] end_discharge_level_two,
  input  wire        cell_undervoltage_flag,
  input  wire [15:0] remaining_capacity,
  input  wire [15:0] full_charge_capacity,
  input  wire [6:0]  battery_low_pct,
  input  wire [6:0]  relative_charge_pct,
  input  wire [6:0]  fully_charged_clear_pct,
  input  wire [15:0] capacity_alarm_level,
  input  wire [15:0] time_alarm_level,
  input  wire [15:0] mean_time_to_empty,
  input  wire [15:0] temperature,
  input  wire [15:0] max_temperature_limit,
  input  wire        overcharge_exceeded,
  input  wire        charge_param_bad,
  input  wire        primary_termination,
  input  wire        charge_activity,
  input  wire        discharge_activity,
  input  wire [7:0]  digital_filter,
  // Configuration load
  input  wire        config_load_ok,
  input  wire        config_load_bad,
  input  wire        capacity_units_sel,
  input  wire [15:0] nv_design_capacity_mah,
  input  wire [15:0] nv_design_capacity_mwh,
  input  wire [15:0] nv_design_voltage,
  input  wire [15:0] nv_spec_info,
  input  wire [15:0] nv_cycle_count,
  // Cycle counting and write-back
  input  wire        cycle_step,
  output reg         nv_cycle_write,
  output reg  [15:0] nv_cycle_data,
  // Live status word
  output reg  [15:0] status_word
);

  ////////////////////////////////////////////////////////////////////////////
  // Function code classes
  function [1:0] code_class;
    input [7:0] code;
    begin
      if (code >= `FC_STATUS_WORD && code <= `FC_SPEC_INFO)
        code_class = 2'd0;
      else if (code >= `FC_RSVD_LO_FIRST && code <= `FC_RSVD_LO_LAST)
        code_class = 2'd2;
      // Past the defined range everything reads as reserved
      else if (code <= `FC_DEFINED_LAST)
        code_class = 2'd1;
      else
        code_class = 2'd2;
    end
  endfunction

  // Classes returned by code_class
  localparam CLS_HERE     = 2'd0;
  localparam CLS_DEFINED  = 2'd1;
  localparam CLS_RESERVED = 2'd2;

  ////////////////////////////////////////////////////////////////////////////
  // Flag state
  reg        over_charged_alarm;
  reg        stop_charge_alarm_flag;
  reg        over_temp_alarm;
  reg        stop_discharge_alarm_flag;
  reg        capacity_alarm;
  reg        time_alarm;
  reg        config_loaded_flag;
  reg        discharging_flag;
  reg        fully_charged_flag;
  reg        fully_discharged_flag;
  reg [2:0]  error_code;
  reg [15:0] cycle_count;
  // Previous samples tell a charge-driven rise from a level change
  reg [15:0] prev_capacity;
  reg [15:0] prev_time;
  reg [15:0] design_capacity;
  reg [15:0] design_voltage;
  reg [15:0] spec_word;

  // One-second tick and idle time
  reg [CNT_W-1:0] sec_div;
  reg             sec_tick;
  reg [11:0]      idle_seconds;

  // Ten seconds per filter step; 2550 at most, twelve bits hold it
  wire [31:0] filter_product = digital_filter * `FILTER_SECONDS_PER;
  wire [11:0] filter_limit   = filter_product[11:0];
  wire        any_activity = charge_activity | discharge_activity;
  wire        idle_expired = (idle_seconds >= filter_limit);
  wire        charging     = charge_activity & ~discharge_activity;

  // Low-capacity test scaled to avoid a divider
  wire [22:0] cap_scaled   = remaining_capacity * `PERCENT_SCALE;
  wire [22:0] cap_low_mark = full_charge_capacity * battery_low_pct;

  ////////////////////////////////////////////////////////////////////////////
  // Seconds divider and idle timer
  // Sim runs shorten the second through SEC_CYCLES
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      sec_div      <= {CNT_W{1'b0}};
      sec_tick     <= 1'b0;
      idle_seconds <= 12'h000;
    end
    else
    begin
      sec_tick <= 1'b0;
      if (sec_div == SEC_CYCLES - 1)
      begin
        sec_div  <= {CNT_W{1'b0}};
        sec_tick <= 1'b1;
      end
      else
        sec_div <= sec_div + 1'b1;
      // Any activity restarts the idle count
      if (any_activity)
        idle_seconds <= 12'h000;
      else if (sec_tick && !idle_expired)
        idle_seconds <= idle_seconds + 12'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Alarm and status flags
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      over_charged_alarm        <= 1'b0;
      stop_charge_alarm_flag    <= 1'b0;
      over_temp_alarm           <= 1'b0;
      stop_discharge_alarm_flag <= 1'b0;
      capacity_alarm            <= 1'b0;
      time_alarm                <= 1'b0;
      discharging_flag          <= 1'b0;
      fully_charged_flag        <= 1'b0;
      fully_discharged_flag     <= 1'b0;
      prev_capacity             <= `RST_WORD;
      prev_time                 <= `RST_WORD;
    end
    else
    begin
      // Idle clear runs between updates so the timeout is not update-bound
      if (over_charged_alarm && !overcharge_exceeded
          && !any_activity && idle_expired)
        over_charged_alarm <= 1'b0;
      if (gauge_update)
      begin
        prev_capacity <= remaining_capacity;
        prev_time     <= mean_time_to_empty;
        // Set wins over clear on every flag
        if (overcharge_exceeded && charging)
          over_charged_alarm <= 1'b1;
        else if (discharge_activity)
          over_charged_alarm <= 1'b0;
        if (charging && (charge_param_bad || primary_termination))
          stop_charge_alarm_flag <= 1'b1;
        else
          stop_charge_alarm_flag <= 1'b0;
        over_temp_alarm <= (temperature >= max_temperature_limit);
        if (pack_voltage <= end_discharge_level_zero || cell_undervoltage_flag
            || remaining_capacity == 16'h0000)
          stop_discharge_alarm_flag <= 1'b1;
        else
          stop_discharge_alarm_flag <= 1'b0;
        // Equal to the level leaves the alarm as it stands, unless charging with capacity above the previous sample
        if (remaining_capacity < capacity_alarm_level)
          capacity_alarm <= 1'b1;
        else if (capacity_alarm_level < remaining_capacity
                 || (charging && remaining_capacity > prev_capacity))
          capacity_alarm <= 1'b0;
        if (mean_time_to_empty < time_alarm_level)
          time_alarm <= 1'b1;
        else if (time_alarm_level < mean_time_to_empty
                 || (charging && mean_time_to_empty > prev_time))
          time_alarm <= 1'b0;
        discharging_flag <= ~charging;
        if (primary_termination || overcharge_exceeded)
          fully_charged_flag <= 1'b1;
        else if (relative_charge_pct <= fully_charged_clear_pct)
          fully_charged_flag <= 1'b0;
        if (pack_voltage <= end_discharge_level_two || cap_scaled < cap_low_mark)
          fully_discharged_flag <= 1'b1;
        else if (relative_charge_pct >= `FULL_DISCH_CLEAR_PCT)
          fully_discharged_flag <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration copies and loaded flag
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      config_loaded_flag <= 1'b0;
      design_capacity    <= `RST_WORD;
      design_voltage     <= `RST_WORD;
      spec_word          <= `RST_WORD;
    end
    else
    begin
      if (config_load_ok)
      begin
        config_loaded_flag <= 1'b1;
        design_voltage     <= nv_design_voltage;
        spec_word          <= nv_spec_info;
      end
      // A bad load keeps the last good voltage and spec copies
      else if (config_load_bad)
        config_loaded_flag <= 1'b0;
      // Units follow the live select bit
      design_capacity <= capacity_units_sel ? nv_design_capacity_mwh
                                            : nv_design_capacity_mah;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cycle counter with saturation and write-back
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cycle_count    <= `RST_WORD;
      nv_cycle_write <= 1'b0;
      nv_cycle_data  <= `RST_WORD;
    end
    else
    begin
      nv_cycle_write <= 1'b0;
      // A load in the same cycle as a step wins
      if (config_load_ok)
        cycle_count <= nv_cycle_count;
      // At the ceiling nothing is written; the copy already holds it
      else if (cycle_step && cycle_count != `CYCLE_MAX)
      begin
        cycle_count    <= cycle_count + 16'h0001;
        nv_cycle_write <= 1'b1;
        nv_cycle_data  <= cycle_count + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function access and error code
  // Busy answers carry no data so a retry reads fresh values
  reg [15:0] next_rdata;
  reg [2:0]  next_error;

  always @*
  begin
    next_rdata = `RST_WORD;
    next_error = `ERR_OK;
    case (code_class(func_code))
      CLS_HERE:
      begin
        if (func_write)
          next_error = `ERR_WRITE_DENIED;
        case (func_code)
          `FC_STATUS_WORD:     next_rdata = status_word;
          `FC_CYCLE_COUNT:     next_rdata = cycle_count;
          `FC_DESIGN_CAPACITY: next_rdata = design_capacity;
          `FC_DESIGN_VOLTAGE:  next_rdata = design_voltage;
          `FC_SPEC_INFO:       next_rdata = spec_word;
          default:             next_rdata = `RST_WORD;
        endcase
      end
      CLS_DEFINED:  next_error = `ERR_UNSUPPORTED;
      CLS_RESERVED: next_error = `ERR_RESERVED;
      default:      next_error = `ERR_UNKNOWN;
    endcase
    // Overflow and busy outrank the decode result
    if (func_overflow)
      next_error = `ERR_OVERFLOW;
    if (func_busy)
    begin
      next_error = `ERR_BUSY;
      next_rdata = `RST_WORD;
    end
  end

  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      func_ack   <= 1'b0;
      func_rdata <= `RST_WORD;
      error_code <= `RST_ERR;
    end
    else
    begin
      // Writes return no data; the error code stands until the next request
      func_ack <= func_req;
      if (func_req)
      begin
        func_rdata <= func_write ? `RST_WORD : next_rdata;
        error_code <= next_error;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status word packing, reserved bits read zero
  // Registered so every output bit comes straight from a flop
  always @(posedge ref_clk)
  begin
    if (!rst_n)
      status_word <= `RST_WORD;
    else
    begin
      status_word                      <= `RST_WORD;
      status_word[`ST_OVER_CHARGED]    <= over_charged_alarm;
      status_word[`ST_STOP_CHARGE]     <= stop_charge_alarm_flag;
      status_word[`ST_OVER_TEMP]       <= over_temp_alarm;
      status_word[`ST_STOP_DISCHARGE]  <= stop_discharge_alarm_flag;
      status_word[`ST_CAPACITY_ALARM]  <= capacity_alarm;
      status_word[`ST_TIME_ALARM]      <= time_alarm;
      status_word[`ST_CONFIG_LOADED]   <= config_loaded_flag;
      status_word[`ST_DISCHARGING]     <= discharging_flag;
      status_word[`ST_FULLY_CHARGED]   <= fully_charged_flag;
      status_word[`ST_FULLY_DISCHARGED] <= fully_discharged_flag;
      status_word[`ST_ERR_MSB:`ST_ERR_LSB] <= error_code;
    end
  end

endmodule // battery_status_flag_logic

// >>> bench/status_flag_checker_sva.sv
// Port checker for the status flag and read-only function block
module status_flag_checker (
  // Clock and reset
  input wire        ref_clk,
  input wire        rst_n,
  // Function port
  input wire        func_req,
  input wire        func_write,
  input wire [7:0]  func_code,
  input wire        func_busy,
  input wire        func_overflow,
  input wire        func_ack,
  // Measurements, counting, status
  input wire        gauge_update,
  input wire [15:0] temperature,
  input wire [15:0] max_temperature_limit,
  input wire [15:0] remaining_capacity,
  input wire        cycle_step,
  input wire        nv_cycle_write,
  input wire [15:0] nv_cycle_data,
  input wire [15:0] status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  wire temp_at_limit = (temperature >= max_temperature_limit);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////
  a_ack_one_cycle: assert property (func_ack == $past(func_req))
    else $error("ack does not follow request by one cycle");
  a_busy_code: assert property (func_req && func_busy |-> ##2 status_word[2:0] == 3'h1)
    else $error("busy request without busy code");
  // Overflow excluded: it outranks a denied write and sets the overflow code
  a_denied_write: assert property (func_req && func_write && !func_busy && !func_overflow
    && func_code >= 8'h16 && func_code <= 8'h1A |-> ##2 status_word[2:0] == 3'h4)
    else $error("read-only write without denied code");
  a_reserved_code: assert property (func_req && !func_busy && !func_overflow
    && func_code > 8'h23 |-> ##2 status_word[2:0] == 3'h2)
    else $error("reserved code missing");
  a_over_temp: assert property (gauge_update |->
    ##2 status_word[12] == $past(temp_at_limit, 2))
    else $error("over temperature flag wrong");
  a_empty_stop: assert property (gauge_update && remaining_capacity == 16'h0000
    |-> ##2 status_word[11])
    else $error("stop discharge flag missing at empty");
  a_write_on_step: assert property (nv_cycle_write |-> $past(cycle_step))
    else $error("count write without step");
  a_count_by_one: assert property (nv_cycle_write && $past(nv_cycle_write)
    |-> nv_cycle_data == $past(nv_cycle_data) + 16'h0001)
    else $error("count not stepped by one");
  a_unused_bits: assert property ((status_word & 16'h2408) == 16'h0000)
    else $error("unused status bits set");
  c_denied: cover property (func_req && func_write);
  c_step: cover property (nv_cycle_write);
  c_empty: cover property (gauge_update && remaining_capacity == 16'h0000);
endmodule // status_flag_checker

bind battery_status_flag_logic status_flag_checker chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .func_req(func_req), .func_write(func_write),
  .func_code(func_code), .func_busy(func_busy), .func_overflow(func_overflow),
  .func_ack(func_ack), .gauge_update(gauge_update), .temperature(temperature),
  .max_temperature_limit(max_temperature_limit), .remaining_capacity(remaining_capacity),
  .cycle_step(cycle_step), .nv_cycle_write(nv_cycle_write),
  .nv_cycle_data(nv_cycle_data), .status_word(status_word));

// >>> bench/smbus_host_model.sv
// Host side model issuing one read-word or write access at a time
module smbus_host_model (
  // Clock
  input  wire        ref_clk,
  // Function access
  output reg         func_req      = 1'b0,
  output reg         func_write    = 1'b0,
  output reg  [7:0]  func_code     = 8'h00,
  output reg         func_busy     = 1'b0,
  output reg         func_overflow = 1'b0,
  input  wire        func_ack,
  input  wire [15:0] func_rdata,
  input  wire [15:0] status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // Entered at a falling edge; request is a one-cycle pulse
  task access(input w, input [7:0] c, input b, input o,
              output [15:0] d, output [2:0] e, output a);
    func_req = 1'b1;
    func_write = w;
    func_code = c;
    func_busy = b;
    func_overflow = o;
    @(negedge ref_clk);
    a = func_ack;
    d = func_rdata;
    // Released lines must not keep showing the last request
    func_req = 1'b0;
    func_write = ~w;
    func_code = ~c;
    func_busy = 1'b0;
    func_overflow = 1'b0;
    repeat (2) @(negedge ref_clk);
    e = status_word[2:0];
  endtask
endmodule // smbus_host_model

// >>> bench/testbench.sv
// Self-checking bench for the status flag block
`include "battery_status_defines.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  reg         ref_clk, rst_n, upd, uv, ovc, pbad, term, chg, dchg, ld_ok, ld_bad, units, step;
  reg  [15:0] volt, lvl0, lvl2, rcap, fcc, cap_lvl, time_lvl, tte, temp, tmax;
  reg  [15:0] nv_mah, nv_mwh, nv_volt, nv_spec, nv_count, rd, cnt;
  reg  [6:0]  low_pct, rel_pct, full_pct;
  reg  [7:0]  filt, code;
  reg  [2:0]  er;
  reg  [31:0] rnd;
  reg         ak, wr, bsy, ovf, cap_prev, time_prev;
  integer     seed, mismatches, tests_run, cycles, i;
  wire        func_req, func_write, func_busy, func_overflow, func_ack, nv_cycle_write;
  wire [7:0]  func_code;
  wire [15:0] func_rdata, nv_cycle_data, status_word;
  ////////////////////////////////////////////////////////////////////////////
  battery_status_flag_logic #(.SEC_CYCLES(10)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n), .func_req(func_req), .func_write(func_write),
    .func_code(func_code), .func_busy(func_busy), .func_overflow(func_overflow),
    .func_ack(func_ack), .func_rdata(func_rdata), .gauge_update(upd), .pack_voltage(volt),
    .end_discharge_level_zero(lvl0), .end_discharge_level_two(lvl2),
    .cell_undervoltage_flag(uv), .remaining_capacity(rcap), .full_charge_capacity(fcc),
    .battery_low_pct(low_pct), .relative_charge_pct(rel_pct),
    .fully_charged_clear_pct(full_pct), .capacity_alarm_level(cap_lvl),
    .time_alarm_level(time_lvl), .mean_time_to_empty(tte), .temperature(temp),
    .max_temperature_limit(tmax), .overcharge_exceeded(ovc), .charge_param_bad(pbad),
    .primary_termination(term), .charge_activity(chg), .discharge_activity(dchg),
    .digital_filter(filt), .config_load_ok(ld_ok), .config_load_bad(ld_bad),
    .capacity_units_sel(units), .nv_design_capacity_mah(nv_mah),
    .nv_design_capacity_mwh(nv_mwh), .nv_design_voltage(nv_volt), .nv_spec_info(nv_spec),
    .nv_cycle_count(nv_count), .cycle_step(step), .nv_cycle_write(nv_cycle_write),
    .nv_cycle_data(nv_cycle_data), .status_word(status_word));
  smbus_host_model host (
    .ref_clk(ref_clk), .func_req(func_req), .func_write(func_write), .func_code(func_code),
    .func_busy(func_busy), .func_overflow(func_overflow), .func_ack(func_ack),
    .func_rdata(func_rdata), .status_word(status_word));
  ////////////////////////////////////////////////////////////////////////////
  function [2:0] exp_err(input w, input [7:0] c, input b, input o);
    if (b) exp_err = `ERR_BUSY;
    else if (o) exp_err = `ERR_OVERFLOW;
    else if (w && c >= `FC_STATUS_WORD && c <= `FC_SPEC_INFO) exp_err = `ERR_WRITE_DENIED;
    else if ((c >= `FC_RSVD_LO_FIRST && c <= `FC_RSVD_LO_LAST) || c > `FC_DEFINED_LAST)
      exp_err = `ERR_RESERVED;
    else if (c < `FC_STATUS_WORD || c > `FC_SPEC_INFO) exp_err = `ERR_UNSUPPORTED;
    else exp_err = `ERR_OK;
  endfunction
  function [15:0] exp_data(input [7:0] c);
    case (c)
      `FC_CYCLE_COUNT: exp_data = cnt;
      `FC_DESIGN_CAPACITY: exp_data = units ? nv_mwh : nv_mah;
      `FC_DESIGN_VOLTAGE: exp_data = nv_volt;
      `FC_SPEC_INFO: exp_data = nv_spec;
      default: exp_data = 16'h0000;
    endcase
  endfunction
  task chk_word(input string what, input [15:0] exp, input [15:0] got);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      mismatches = mismatches + 1;
      $display("MISMATCH %0s expected %h seen %h", what, exp, got);
    end
  endtask
  task chk_code(input string what, input [2:0] exp, input [2:0] got);
    chk_word(what, {13'h0000, exp}, {13'h0000, got});
  endtask
  task chk_flag(input string what, input exp, input got);
    chk_word(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task gauge;
    upd = 1'b1;
    @(negedge ref_clk);
    upd = 1'b0;
    repeat (2) @(negedge ref_clk);
  endtask
  task load(input good);
    ld_ok = good;
    ld_bad = !good;
    @(negedge ref_clk);
    ld_ok = 1'b0;
    ld_bad = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask
  task tally_and_finish;
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Cut a hang short well past the few hundred cycles the run needs
  always @(posedge ref_clk)
  begin
    cycles = cycles + 1;
    if (cycles == 5000)
    begin
      mismatches = mismatches + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    {seed, mismatches, tests_run, cycles, cap_prev, time_prev} = {32'ha117, 96'h0, 2'b00};
    {rst_n, upd, uv, ovc, pbad, term, chg, dchg, ld_ok, ld_bad, units, step} = 12'h000;
    {volt, lvl0, lvl2, rcap, fcc, cap_lvl, time_lvl, tte, temp, tmax} = 160'h0;
    {low_pct, rel_pct, full_pct, filt} = 29'h0;
    {nv_mah, nv_mwh, nv_volt, nv_count} = {$random(seed), $random(seed)};
    nv_spec = {8'h00, nv_mah[7:0]};
    nv_count[15] = 1'b0;
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    chk_word("reset_status", 16'h0000, status_word);
    load(1'b1);
    chk_flag("loaded", 1'b1, status_word[`ST_CONFIG_LOADED]);
    load(1'b0);
    chk_flag("loaded", 1'b0, status_word[`ST_CONFIG_LOADED]);
    for (i = 0; i < 2; i = i + 1)
    begin
      if (i == 1) nv_count = 16'hFFFE;
      load(1'b1);
      step = 1'b1;
      @(negedge ref_clk);
      chk_flag("nv_write", 1'b1, nv_cycle_write);
      chk_word("nv_data", nv_count + 16'h0001, nv_cycle_data);
      @(negedge ref_clk);
      step = 1'b0;
      chk_flag("nv_write", i == 0, nv_cycle_write);
      chk_word("nv_data", i ? 16'hFFFF : nv_count + 16'h0002, nv_cycle_data);
    end
    cnt = 16'hFFFF;
    for (i = 0; i < 60; i = i + 1)
    begin
      rnd = $random(seed);
      {units, ovf, bsy, wr, code} = {rnd[17], rnd[16:13] == 4'h0, rnd[12:9] == 4'h0, rnd[8:0]};
      if (i < 5) {wr, bsy, ovf, code} = {3'b100, 8'h16 + i[7:0]};
      if (i == 5 || i == 6) {wr, bsy, ovf, code} = {1'b0, i == 5, i == 6, `FC_CYCLE_COUNT};
      if (i >= 7 && i < 15) {wr, bsy, ovf, code} = {3'b000, 8'h17 + {6'h00, i[1:0]}};
      if (code == `FC_STATUS_WORD) wr = 1'b1;
      // Capacity copy follows the units select one edge later
      @(negedge ref_clk);
      host.access(wr, code, bsy, ovf, rd, er, ak);
      chk_flag("ack", 1'b1, ak);
      chk_code("error_code", exp_err(wr, code, bsy, ovf), er);
      chk_word("rdata", (wr || bsy) ? 16'h0000 : exp_data(code), rd);
    end
    for (i = 0; i < 40; i = i + 1)
    begin
      {volt, lvl0, lvl2, rcap} = {$random(seed), $random(seed)};
      {fcc, cap_lvl, time_lvl, tte} = {$random(seed), $random(seed)};
      {temp, tmax} = $random(seed);
      {uv, ovc, pbad, term, dchg, filt, rel_pct, low_pct, full_pct[4:0]} = $random(seed);
      if (i == 0) rcap = 16'h0000;
      if (i == 1) cap_lvl = rcap;
      if (i == 2) time_lvl = tte;
      if (i == 3) temp = tmax;
      gauge;
      cap_prev = rcap < cap_lvl ? 1'b1 : (rcap > cap_lvl ? 1'b0 : cap_prev);
      time_prev = tte < time_lvl ? 1'b1 : (tte > time_lvl ? 1'b0 : time_prev);
      chk_flag("over_temp", temp >= tmax, status_word[`ST_OVER_TEMP]);
      chk_flag("stop_discharge", volt <= lvl0 || uv || rcap == 16'h0000,
               status_word[`ST_STOP_DISCHARGE]);
      chk_flag("capacity_alarm", cap_prev, status_word[`ST_CAPACITY_ALARM]);
      chk_flag("time_alarm", time_prev, status_word[`ST_TIME_ALARM]);
      chk_flag("discharging", 1'b1, status_word[`ST_DISCHARGING]);
    end
    {chg, dchg, term, ovc, pbad, rel_pct, full_pct} = {5'b10110, 7'd100, 7'd50};
    gauge;
    chk_flag("discharging", 1'b0, status_word[`ST_DISCHARGING]);
    chk_flag("fully_charged", 1'b1, status_word[`ST_FULLY_CHARGED]);
    chk_flag("over_charged", 1'b1, status_word[`ST_OVER_CHARGED]);
    chk_flag("stop_charge", 1'b1, status_word[`ST_STOP_CHARGE]);
    {chg, dchg, term, ovc, rel_pct, volt} = {4'b0100, 7'd50, 16'h0000};
    gauge;
    chk_flag("over_charged", 1'b0, status_word[`ST_OVER_CHARGED]);
    chk_flag("stop_charge", 1'b0, status_word[`ST_STOP_CHARGE]);
    chk_flag("fully_charged", 1'b0, status_word[`ST_FULLY_CHARGED]);
    chk_flag("fully_discharged", 1'b1, status_word[`ST_FULLY_DISCHARGED]);
    {volt, lvl2, rcap, fcc, low_pct, rel_pct} = {32'hFFFF_0000, 32'h1000_1000, 7'd0, 7'd20};
    gauge;
    chk_flag("fully_discharged", 1'b0, status_word[`ST_FULLY_DISCHARGED]);
    {chg, dchg, ovc, filt} = {3'b101, 8'h01};
    gauge;
    chk_flag("over_charged", 1'b1, status_word[`ST_OVER_CHARGED]);
    {chg, ovc} = 2'b00;
    repeat (60) @(negedge ref_clk);
    chk_flag("over_charged", 1'b1, status_word[`ST_OVER_CHARGED]);
    repeat (60) @(negedge ref_clk);
    chk_flag("over_charged", 1'b0, status_word[`ST_OVER_CHARGED]);
    tally_and_finish;
  end
endmodule // testbench
